// ### bench/sigmod_src_model.sv
// Behavioural model of the peripherals and pins that feed the modulator
module sigmod_src_model (
	// Clock
	input wire logic clk,
	// Levels requested by the bench
	input wire sigmod_pkg::sigmod_src_t level_req,
	// Levels seen by the modulator
	output sigmod_pkg::sigmod_src_t source_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Peripheral outputs are registered, so they only move just after an edge
	always_ff @(posedge clk) begin
		source_out <= level_req;
	end
endmodule // sigmod_src_model

// ### bench/tb_top.sv
// Self-checking bench of the signal modulator with a reference model
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, reset_n, clk_en, pd, psel, penable, pwrite, pready, pslverr, pin;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	sigmod_pkg::sigmod_src_t src_req, src_now, cur, v;
	int errors, checks_done, k, sy, hi;
	int c_en, c_output_invert, c_sw, c_carrier_high_invert, c_carrier_high_sync, c_carrier_low_invert, c_carrier_low_sync, c_src, c_chs, c_cls;
	logic [15:0] addrs [5];
	int masks [5];
	sigmod_src_model i_src (.clk(clk), .level_req(src_req), .source_out(src_now));
	sigmod_top i_dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.modulator_power_down_bit(pd), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.source_in(src_now), .modulated_output_pin(pin));
	// ------------------------------------------------------------
	// Checking and reference model
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	function automatic logic mod_of(int c, sigmod_pkg::sigmod_src_t s, logic sw);
		case (c)
			0: return s.mod_pin;
			1: return sw;
			2, 3, 4, 5: return s.compare[c-2];
			6, 7: return s.pwm[c-6];
			8: return s.nco;
			9, 10: return s.comparator[c-9];
			11, 12, 13, 14: return s.logic_cell[c-11];
			15: return s.serial_tx;
			16, 17: return s.sync_sdo[c-16];
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic car_of(int c, sigmod_pkg::sigmod_src_t s, logic own);
		case (c)
			0: return own;
			1: return s.system_clock;
			2: return s.fast_osc;
			3: return s.ref_clk;
			4, 5, 6, 7: return s.compare[c-4];
			8, 9: return s.pwm[c-8];
			10: return s.nco;
			11, 12, 13, 14: return s.logic_cell[c-11];
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic exp_pin();
		logic m, c;
		m = mod_of(c_src, cur, c_sw[0]);
		c = m ? car_of(c_chs, cur, cur.carrier_high_pin) ^ c_carrier_high_invert[0] : car_of(c_cls, cur, cur.carrier_low_pin) ^ c_carrier_low_invert[0];
		return c_en[0] & (c ^ c_output_invert[0]);
	endfunction
	// ------------------------------------------------------------
	// APB master and stimulus tasks
	// ------------------------------------------------------------
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] d, output logic er);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			check("apb_wait", 32'h0, 32'h1);
		end
		d = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input int d);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, 32'(d), r, er);
	endtask
	task automatic rdchk(input string nm, input logic [15:0] a, input int e);
		logic er;
		apb(1'b0, a, 32'h0, rd, er);
		check(nm, rd, 32'(e));
	endtask
	task automatic set_src(input sigmod_pkg::sigmod_src_t s);
		cur = s;
		src_req <= s;
	endtask
	task automatic cfg_apply();
		wr(addrs[0], 0);
		wr(addrs[1], (c_carrier_high_invert << 5) | (c_carrier_high_sync << 4) | (c_carrier_low_invert << 1) | c_carrier_low_sync);
		wr(addrs[2], c_src);
		wr(addrs[3], c_cls);
		wr(addrs[4], c_chs);
		wr(addrs[0], (c_en << 7) | (c_output_invert << 4) | c_sw);
	endtask
	// Source changes pass three flops, a filter and the output flop
	task automatic check_pin();
		logic e;
		e = exp_pin();
		repeat (10) @(posedge clk);
		check("pin", {31'h0, pin}, {31'h0, e});
		rdchk("out_status", addrs[0], (c_en << 7) | (e << 5) | (c_output_invert << 4) | c_sw);
	endtask
	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		final_report();
	end
	initial begin
		{reset_n, pd, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		src_req = '0;
		addrs = '{sigmod_pkg::SIGMOD_ADDR_CON0, sigmod_pkg::SIGMOD_ADDR_CON1,
			sigmod_pkg::SIGMOD_ADDR_SRC, sigmod_pkg::SIGMOD_ADDR_CARRIER_LOW, sigmod_pkg::SIGMOD_ADDR_CARRIER_HIGH};
		masks = '{'h11, 'h33, 'h1f, 'h0f, 'h0f};
		{c_en, c_output_invert, c_sw, c_carrier_high_invert, c_carrier_high_sync, c_carrier_low_invert, c_carrier_low_sync, c_src, c_chs, c_cls} = '0;
		k = $urandom(53);
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		for (k = 0; k < 5; k++) rdchk("reset_value", addrs[k], 0);
		apb(1'b0, 16'h2270, 32'h0, rd, v[0]);
		check("unmapped_err", {31'h0, v[0]}, 32'h1);
		// Status bit must ignore writes; EN is kept clear so the output stays low
		for (k = 0; k < 5; k++) begin
			sy = (k == 0) ? ($urandom & 'h7f) | 'h20 : $urandom;
			wr(addrs[k], sy);
			rdchk("readback", addrs[k], sy & masks[k]);
		end
		c_en = 1;
		c_src = 1;
		c_sw = 1;
		set_src(22'h2);
		cfg_apply();
		check_pin();
		pd <= 1'b1;
		wr(addrs[1], 'h33);
		check("pin_powerdown", {31'h0, pin}, 32'h0);
		pd <= 1'b0;
		for (k = 0; k < 5; k++) rdchk("powerdown_value", addrs[k], 0);
		for (k = 0; k < 48; k++) begin
			c_src = k % 32;
			c_chs = k % 16;
			c_cls = 15 - (k % 16);
			c_en = (k % 8) != 3;
			sy = $urandom;
			c_output_invert = sy & 1;
			c_sw = (sy >> 1) & 1;
			c_carrier_high_invert = (sy >> 2) & 1;
			c_carrier_low_invert = (sy >> 3) & 1;
			set_src(22'($urandom));
			cfg_apply();
			check_pin();
		end
		c_en = 1;
		c_src = 1;
		c_sw = 1;
		c_chs = 2;
		{c_output_invert, c_carrier_high_invert, c_carrier_low_invert} = '0;
		set_src(22'h10);
		cfg_apply();
		check_pin();
		c_en = 0;
		c_output_invert = 1;
		wr(addrs[0], 'h11);
		check_pin();
		rdchk("kept_source", addrs[2], 1);
		c_en = 1;
		c_output_invert = 0;
		wr(addrs[0], 'h81);
		check_pin();
		// With the clock enable low the output must hold although the carrier drops
		clk_en <= 1'b0;
		set_src(22'h0);
		repeat (10) @(posedge clk);
		check("frozen_pin", {31'h0, pin}, 32'h1);
		clk_en <= 1'b1;
		check_pin();
		// Carrier held at 1 while the modulator flips shows whether a sync wait happens
		for (k = 0; k < 4; k++) begin
			hi = k < 2;
			sy = k % 2;
			{c_src, c_chs, c_cls, c_sw, c_output_invert} = '0;
			c_carrier_high_sync = hi ? sy : 0;
			c_carrier_low_sync = hi ? 0 : sy;
			v = '0;
			v.carrier_high_pin = hi[0];
			v.carrier_low_pin = !hi[0];
			v.mod_pin = hi[0];
			set_src(v);
			cfg_apply();
			check_pin();
			v.mod_pin = !hi[0];
			set_src(v);
			repeat (10) @(posedge clk);
			check("sync_hold", {31'h0, pin}, 32'(sy));
			// Swap the carriers: the held one falls and the new one shows high
			v.carrier_high_pin = !hi[0];
			v.carrier_low_pin = hi[0];
			set_src(v);
			repeat (10) @(posedge clk);
			check("sync_release", {31'h0, pin}, 32'h1);
		end
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		check("pin_reset", {31'h0, pin}, 32'h0);
		reset_n <= 1'b1;
		for (k = 0; k < 5; k++) rdchk("rereset_value", addrs[k], 0);
		final_report();
	end
endmodule // tb_top

// ### hw/sigmod_pkg.sv
// Shared constants, register layout and signal bundles of the signal modulator
package sigmod_pkg;

	// ------------------------------------------------------------
	// Register indexes and byte addresses
	// ------------------------------------------------------------
	localparam logic [15:0] SIGMOD_IDX_CON0 = 16'h0897;
	localparam logic [15:0] SIGMOD_IDX_CON1 = 16'h0898;
	localparam logic [15:0] SIGMOD_IDX_SRC = 16'h0899;
	localparam logic [15:0] SIGMOD_IDX_CARRIER_LOW = 16'h089a;
	localparam logic [15:0] SIGMOD_IDX_CARRIER_HIGH = 16'h089b;
	localparam logic [15:0] SIGMOD_ADDR_CON0 = {SIGMOD_IDX_CON0[13:0], 2'h0};
	localparam logic [15:0] SIGMOD_ADDR_CON1 = {SIGMOD_IDX_CON1[13:0], 2'h0};
	localparam logic [15:0] SIGMOD_ADDR_SRC = {SIGMOD_IDX_SRC[13:0], 2'h0};
	localparam logic [15:0] SIGMOD_ADDR_CARRIER_LOW = {SIGMOD_IDX_CARRIER_LOW[13:0], 2'h0};
	localparam logic [15:0] SIGMOD_ADDR_CARRIER_HIGH = {SIGMOD_IDX_CARRIER_HIGH[13:0], 2'h0};

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SIGMOD_CON0_EN = 7;
	localparam int SIGMOD_CON0_OUT = 5;
	localparam int SIGMOD_CON0_OUTPUT_INVERT = 4;
	localparam int SIGMOD_CON0_BIT = 0;
	localparam int SIGMOD_CON1_CARRIER_HIGH_INVERT = 5;
	localparam int SIGMOD_CON1_CARRIER_HIGH_SYNC = 4;
	localparam int SIGMOD_CON1_CARRIER_LOW_INVERT = 1;
	localparam int SIGMOD_CON1_CARRIER_LOW_SYNC = 0;
	localparam int SIGMOD_SRC_W = 5;
	localparam int SIGMOD_CAR_W = 4;
	localparam int SIGMOD_SYNC_STAGES = 3;

	// ------------------------------------------------------------
	// Source select codes
	// ------------------------------------------------------------
	localparam logic [4:0] SIGMOD_SRC_PIN = 5'h00;
	localparam logic [4:0] SIGMOD_SRC_SWBIT = 5'h01;
	localparam logic [4:0] SIGMOD_SRC_LAST = 5'h11;
	localparam logic [3:0] SIGMOD_CAR_PIN = 4'h0;
	localparam logic [3:0] SIGMOD_CAR_SYSCLK = 4'h1;
	localparam logic [3:0] SIGMOD_CAR_FASTOSC = 4'h2;
	localparam logic [3:0] SIGMOD_CAR_REFCLK = 4'h3;
	localparam logic [3:0] SIGMOD_CAR_RSVD = 4'hf;

	// ------------------------------------------------------------
	// Bundles
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] sync_sdo;
		logic serial_tx;
		logic [3:0] logic_cell;
		logic [1:0] comparator;
		logic nco;
		logic [1:0] pwm;
		logic [3:0] compare;
		logic ref_clk;
		logic fast_osc;
		logic system_clock;
		logic carrier_low_pin;
		logic carrier_high_pin;
		logic mod_pin;
	} sigmod_src_t;

	typedef struct packed {
		logic en;
		logic output_invert;
		logic swbit;
		logic carrier_high_invert;
		logic carrier_high_sync;
		logic carrier_low_invert;
		logic carrier_low_sync;
		logic [4:0] src;
		logic [3:0] carrier_high_select_field;
		logic [3:0] carrier_low_select_field;
	} sigmod_cfg_t;

	localparam sigmod_cfg_t SIGMOD_CFG_RESET = '0;

endpackage

// ### hw/sigmod_sync.sv
// Three-stage input synchroniser with agreement filter, one lane per bit
module sigmod_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Signals
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
	logic [WIDTH-1:0] out_next;

	// A lane changes only once stages two and three agree
	always_comb begin
		out_next = (s2_reg & s3_reg) | (out_reg & (s2_reg | s3_reg));
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			out_reg <= '0;
		end else if (clk_en) begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			out_reg <= out_next;
		end
	end

	assign sync_out = out_reg;

endmodule // sigmod_sync

// ### hw/sigmod_top.sv
// Signal modulator: APB registers, source selection, carrier sync and output
module sigmod_top (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Power management
	input wire logic modulator_power_down_bit,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Signal sources
	input wire sigmod_pkg::sigmod_src_t source_in,
	// Modulated output
	output logic modulated_output_pin
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam int SRC_BITS = $bits(sigmod_pkg::sigmod_src_t);

	sigmod_pkg::sigmod_cfg_t cfg_reg, cfg_next;
	sigmod_pkg::sigmod_src_t src_sync;
	logic [SRC_BITS-1:0] src_sync_bits;
	logic ack_reg, ack_next;
	logic [31:0] prdata_reg, prdata_next;
	logic pslverr_reg, pslverr_next;
	logic sel_high_reg, sel_high_next;
	logic carrier_high_prev_reg, carrier_high_prev_next;
	logic carrier_low_prev_reg, carrier_low_prev_next;
	logic out_reg, out_next;
	logic addr_hit;
	logic access;
	logic wr_fire;
	logic [7:0] rd_byte;
	logic mod_raw;
	logic [17:0] mod_vec;
	logic [13:0] car_vec;
	logic [14:0] carrier_high_vec, carrier_low_vec;
	logic carrier_high_raw;
	logic carrier_low_raw;
	logic carrier_high_eff;
	logic carrier_low_eff;
	logic carrier_high_fall;
	logic carrier_low_fall;
	logic pd;

	assign pd = modulator_power_down_bit;

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Sampling on clk assumes clk keeps running in sleep; a source faster
	// than half the clk rate is aliased, not mixed
	sigmod_sync #(.WIDTH(SRC_BITS)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.async_in(source_in),
		.sync_out(src_sync_bits)
	);

	assign src_sync = sigmod_pkg::sigmod_src_t'(src_sync_bits);

	// ------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------
	// One wait state: first access cycle loads read data, second completes
	assign access = psel & penable;
	assign wr_fire = access & ack_reg & pwrite;

	always_comb begin
		addr_hit = 1'b1;
		rd_byte = 8'h00;
		case (paddr)
			sigmod_pkg::SIGMOD_ADDR_CON0: begin
				rd_byte[sigmod_pkg::SIGMOD_CON0_EN] = cfg_reg.en;
				rd_byte[sigmod_pkg::SIGMOD_CON0_OUT] = out_reg;
				rd_byte[sigmod_pkg::SIGMOD_CON0_OUTPUT_INVERT] = cfg_reg.output_invert;
				rd_byte[sigmod_pkg::SIGMOD_CON0_BIT] = cfg_reg.swbit;
			end
			sigmod_pkg::SIGMOD_ADDR_CON1: begin
				rd_byte[sigmod_pkg::SIGMOD_CON1_CARRIER_HIGH_INVERT] = cfg_reg.carrier_high_invert;
				rd_byte[sigmod_pkg::SIGMOD_CON1_CARRIER_HIGH_SYNC] = cfg_reg.carrier_high_sync;
				rd_byte[sigmod_pkg::SIGMOD_CON1_CARRIER_LOW_INVERT] = cfg_reg.carrier_low_invert;
				rd_byte[sigmod_pkg::SIGMOD_CON1_CARRIER_LOW_SYNC] = cfg_reg.carrier_low_sync;
			end
			sigmod_pkg::SIGMOD_ADDR_SRC: rd_byte[4:0] = cfg_reg.src;
			sigmod_pkg::SIGMOD_ADDR_CARRIER_LOW: rd_byte[3:0] = cfg_reg.carrier_low_select_field;
			sigmod_pkg::SIGMOD_ADDR_CARRIER_HIGH: rd_byte[3:0] = cfg_reg.carrier_high_select_field;
			default: addr_hit = 1'b0;
		endcase
	end

	always_comb begin
		ack_next = access & ~ack_reg;
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		if (access && !ack_reg) begin
			prdata_next = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			pslverr_next = ~addr_hit;
		end
	end

	assign prdata = prdata_reg;
	assign pready = ack_reg;
	assign pslverr = pslverr_reg & ack_reg;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	always_comb begin
		cfg_next = cfg_reg;
		if (pd) begin
			cfg_next = sigmod_pkg::SIGMOD_CFG_RESET;
		end else if (wr_fire) begin
			case (paddr)
				sigmod_pkg::SIGMOD_ADDR_CON0: begin
					// Selections sit in other registers, so a disable keeps them
					cfg_next.en = pwdata[sigmod_pkg::SIGMOD_CON0_EN];
					cfg_next.output_invert = pwdata[sigmod_pkg::SIGMOD_CON0_OUTPUT_INVERT];
					cfg_next.swbit = pwdata[sigmod_pkg::SIGMOD_CON0_BIT];
				end
				sigmod_pkg::SIGMOD_ADDR_CON1: begin
					cfg_next.carrier_high_invert = pwdata[sigmod_pkg::SIGMOD_CON1_CARRIER_HIGH_INVERT];
					cfg_next.carrier_high_sync = pwdata[sigmod_pkg::SIGMOD_CON1_CARRIER_HIGH_SYNC];
					cfg_next.carrier_low_invert = pwdata[sigmod_pkg::SIGMOD_CON1_CARRIER_LOW_INVERT];
					cfg_next.carrier_low_sync = pwdata[sigmod_pkg::SIGMOD_CON1_CARRIER_LOW_SYNC];
				end
				sigmod_pkg::SIGMOD_ADDR_SRC: cfg_next.src = pwdata[4:0];
				sigmod_pkg::SIGMOD_ADDR_CARRIER_LOW: cfg_next.carrier_low_select_field = pwdata[3:0];
				sigmod_pkg::SIGMOD_ADDR_CARRIER_HIGH: cfg_next.carrier_high_select_field = pwdata[3:0];
				default: cfg_next = cfg_reg;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Source multiplexers
	// ------------------------------------------------------------
	// Inputs laid out in select-code order, so one index serves every code up to the last entry
	assign mod_vec = {src_sync.sync_sdo, src_sync.serial_tx, src_sync.logic_cell,
		src_sync.comparator, src_sync.nco, src_sync.pwm, src_sync.compare, cfg_reg.swbit,
		src_sync.mod_pin};
	assign car_vec = {src_sync.logic_cell, src_sync.nco, src_sync.pwm, src_sync.compare,
		src_sync.ref_clk, src_sync.fast_osc, src_sync.system_clock};
	assign carrier_high_vec = {car_vec, src_sync.carrier_high_pin};
	assign carrier_low_vec = {car_vec, src_sync.carrier_low_pin};

	// Codes past the last entry must not index the vectors
	assign mod_raw = (cfg_reg.src > sigmod_pkg::SIGMOD_SRC_LAST) ? 1'b0 :
		mod_vec[cfg_reg.src];
	assign carrier_high_raw = (cfg_reg.carrier_high_select_field == sigmod_pkg::SIGMOD_CAR_RSVD) ? 1'b0 :
		carrier_high_vec[cfg_reg.carrier_high_select_field];
	assign carrier_low_raw = (cfg_reg.carrier_low_select_field == sigmod_pkg::SIGMOD_CAR_RSVD) ? 1'b0 :
		carrier_low_vec[cfg_reg.carrier_low_select_field];
	assign carrier_high_eff = carrier_high_raw ^ cfg_reg.carrier_high_invert;
	assign carrier_low_eff = carrier_low_raw ^ cfg_reg.carrier_low_invert;

	// ------------------------------------------------------------
	// Carrier switching and output
	// ------------------------------------------------------------
	assign carrier_high_fall = carrier_high_prev_reg & ~carrier_high_eff;
	assign carrier_low_fall = carrier_low_prev_reg & ~carrier_low_eff;

	always_comb begin
		sel_high_next = sel_high_reg;
		carrier_high_prev_next = carrier_high_eff;
		carrier_low_prev_next = carrier_low_eff;
		out_next = 1'b0;
		if (pd) begin
			sel_high_next = 1'b0;
			carrier_high_prev_next = 1'b0;
			carrier_low_prev_next = 1'b0;
		end else begin
			if (!cfg_reg.en) begin
				sel_high_next = mod_raw;
			end else if (sel_high_reg && !mod_raw) begin
				// Without sync a high pulse may be cut short at the switch
				if (!cfg_reg.carrier_high_sync || carrier_high_fall) begin
					sel_high_next = 1'b0;
				end
			end else if (!sel_high_reg && mod_raw) begin
				if (!cfg_reg.carrier_low_sync || carrier_low_fall) begin
					sel_high_next = 1'b1;
				end
			end
			if (cfg_reg.en) begin
				// Active carrier gated by the modulator or its complement
				out_next = (sel_high_next ? carrier_high_eff : carrier_low_eff) ^ cfg_reg.output_invert;
			end
		end
	end

	assign modulated_output_pin = out_reg;

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= sigmod_pkg::SIGMOD_CFG_RESET;
			ack_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			sel_high_reg <= 1'b0;
			carrier_high_prev_reg <= 1'b0;
			carrier_low_prev_reg <= 1'b0;
			out_reg <= 1'b0;
		end else if (clk_en) begin
			cfg_reg <= cfg_next;
			ack_reg <= ack_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
			sel_high_reg <= sel_high_next;
			carrier_high_prev_reg <= carrier_high_prev_next;
			carrier_low_prev_reg <= carrier_low_prev_next;
			out_reg <= out_next;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	logic run;
	assign run = clk_en & cfg_reg.en & ~pd;

	sequence s_wait_high;
		run && sel_high_reg && !mod_raw && cfg_reg.carrier_high_sync && !carrier_high_fall;
	endsequence

	sequence s_wait_low;
		run && !sel_high_reg && mod_raw && cfg_reg.carrier_low_sync && !carrier_low_fall;
	endsequence

	property p_mix_high;
		run && mod_raw && (sel_high_reg || !cfg_reg.carrier_low_sync)
			|=> modulated_output_pin == ($past(carrier_high_eff) ^ $past(cfg_reg.output_invert));
	endproperty
	a_mix_high: assert property (p_mix_high) else $error("high carrier not mixed");

	property p_mix_low;
		run && !mod_raw && (!sel_high_reg || !cfg_reg.carrier_high_sync)
			|=> modulated_output_pin == ($past(carrier_low_eff) ^ $past(cfg_reg.output_invert));
	endproperty
	a_mix_low: assert property (p_mix_low) else $error("low carrier not mixed");

	property p_disabled_low;
		clk_en && !cfg_reg.en |=> !modulated_output_pin;
	endproperty
	a_disabled_low: assert property (p_disabled_low) else $error("output not low when off");

	property p_disable_keeps;
		clk_en && wr_fire && paddr == sigmod_pkg::SIGMOD_ADDR_CON0 && !pd
			|=> cfg_reg.src == $past(cfg_reg.src) && cfg_reg.carrier_high_select_field == $past(cfg_reg.carrier_high_select_field);
	endproperty
	a_disable_keeps: assert property (p_disable_keeps) else $error("selection lost");

	property p_sync_hold;
		s_wait_high or s_wait_low |=> sel_high_reg == $past(sel_high_reg);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("switched before fall");

	property p_sync_switch;
		run && sel_high_reg && !mod_raw && carrier_high_fall ##1 clk_en |-> !sel_high_reg;
	endproperty
	a_sync_switch: assert property (p_sync_switch) else $error("no switch on fall");

	property p_nosync;
		run && !sel_high_reg && mod_raw && !cfg_reg.carrier_low_sync |=> sel_high_reg;
	endproperty
	a_nosync: assert property (p_nosync) else $error("unsynced switch late");

	property p_swbit;
		cfg_reg.src == sigmod_pkg::SIGMOD_SRC_SWBIT |-> mod_raw == cfg_reg.swbit;
	endproperty
	a_swbit: assert property (p_swbit) else $error("software bit not used");

	property p_reserved;
		(cfg_reg.src > sigmod_pkg::SIGMOD_SRC_LAST |-> !mod_raw) and
			(cfg_reg.carrier_high_select_field == sigmod_pkg::SIGMOD_CAR_RSVD |-> !carrier_high_raw);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code not low");

	property p_power_down;
		clk_en && pd |=> cfg_reg == sigmod_pkg::SIGMOD_CFG_RESET && !modulated_output_pin;
	endproperty
	a_power_down: assert property (p_power_down) else $error("power-down not idle");

	property p_status;
		clk_en && access && !ack_reg && !pwrite && paddr == sigmod_pkg::SIGMOD_ADDR_CON0
			|=> prdata[sigmod_pkg::SIGMOD_CON0_OUT] == $past(modulated_output_pin);
	endproperty
	a_status: assert property (p_status) else $error("status bit wrong");

	property p_reset;
		$rose(reset_n) |-> !cfg_reg.en && cfg_reg.src == '0 && !modulated_output_pin;
	endproperty
	a_reset: assert property (p_reset) else $error("reset state wrong");

endmodule // sigmod_top
